// ===== smpg_motor_model.sv
// Behavioural motor driver stage that counts the steps it sees on the four phase lines.
`timescale 1ns/100ps
module smpg_motor_model
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  phase_in,
    output logic      [15:0] steps_seen
);
    logic [3:0] last_q;

    // The all-off gap of a rise delay is not a step, so only a new energised pattern counts.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            last_q     <= 4'h0;
            steps_seen <= 16'h0000;
        end
        else if (phase_in != 4'h0 && phase_in != last_q)
        begin
            last_q     <= phase_in;
            steps_seen <= steps_seen + 16'h0001;
        end
    end
endmodule // smpg_motor_model

// ===== smpg_params.svh
// Register offsets, field positions, reset values and timing counts of the stepper pulse generator.
`ifndef SMPG_PARAMS_SVH
`define SMPG_PARAMS_SVH
`define SMPG_OFS_CTRL      5'h00
`define SMPG_OFS_WAVE      5'h04
`define SMPG_OFS_PERIOD    5'h08
`define SMPG_OFS_RISE      5'h0C
`define SMPG_OFS_STEPS     5'h10
`define SMPG_OFS_STATUS    5'h14
`define SMPG_CTRL_RUN      0
`define SMPG_CTRL_CKSEL_LO 2
`define SMPG_CTRL_STEPFLG  6
`define SMPG_CTRL_HALTFLG  7
`define SMPG_WAVE_MODE_LO  4
`define SMPG_PER_LOW_LO    2
`define SMPG_PER_HIGH_LO   8
`define SMPG_PER_STOP      14
`define SMPG_PER_DIR       15
`define SMPG_RISE_HIGH_LO  8
`define SMPG_RISE_BRK_LO   13
`define SMPG_CTRL_RESET    8'h00
`define SMPG_WAVE_RESET    6'h00
`define SMPG_PER_RESET     16'h0000
`define SMPG_RISE_RESET    16'h0000
`define SMPG_STEPS_RESET   8'h00
`define SMPG_STOP_TICKS    2
`define SMPG_RESUME_TICKS  4
`endif

// ===== smpg_pkg.sv
// Types shared by the stepper pulse generator modules.
package smpg_pkg;
    typedef enum logic [1:0] {SMPG_CK_SYS, SMPG_CK_TMR3, SMPG_CK_PLL, SMPG_CK_LSOSC} smpg_cksel_t;
    typedef enum logic [1:0] {SMPG_ONE_PHASE, SMPG_ONE_TWO, SMPG_TWO_PHASE, SMPG_MODE_RSVD} smpg_mode_t;
    typedef enum logic [1:0] {SMPG_BRK_RUN, SMPG_BRK_STEP_END, SMPG_BRK_ZERO, SMPG_BRK_HOLD} smpg_brk_t;
    typedef enum {SMPG_IDLE, SMPG_RUN, SMPG_HALT, SMPG_BREAK} smpg_state_t;
    typedef struct packed {
        logic [9:0] period;
        logic [1:0] ext;
        logic       dir;
        logic       stop;
        logic [9:0] lowp;
        logic [7:0] steps;
    } smpg_seg_t;
endpackage

// ===== smpg_tick_gen.sv
// Count clock tick generator: selects system clock, timer match or low-speed oscillator.
`timescale 1ns/100ps
module smpg_tick_gen
    import smpg_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic timer3_match,
    input  wire logic low_speed_oscillator,
    smpg_tick_if.gen  tif
);
    logic [1:0] tmr_sync_q;
    logic [1:0] osc_sync_q;
    logic       tmr_last_q;
    logic       osc_last_q;
    wire        tmr_rise = tmr_sync_q[1] & ~tmr_last_q;
    wire        osc_rise = osc_sync_q[1] & ~osc_last_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tmr_sync_q <= 2'h0;
            osc_sync_q <= 2'h0;
            tmr_last_q <= 1'b0;
            osc_last_q <= 1'b0;
        end
        else
        begin
            tmr_sync_q <= {tmr_sync_q[0], timer3_match};
            osc_sync_q <= {osc_sync_q[0], low_speed_oscillator};
            tmr_last_q <= tmr_sync_q[1];
            osc_last_q <= osc_sync_q[1];
        end
    end

    // The PLL source belongs to the ultrasonic mode and never ticks here.
    always_comb
    begin
        case (smpg_cksel_t'(tif.sel))
            SMPG_CK_SYS:   tif.tick = 1'b1;
            SMPG_CK_TMR3:  tif.tick = tmr_rise;
            SMPG_CK_LSOSC: tif.tick = osc_rise;
            default:       tif.tick = 1'b0;
        endcase
    end
endmodule // smpg_tick_gen

// ===== smpg_tick_if.sv
// Count clock selection and tick between the sequencer and the tick generator.
`timescale 1ns/100ps
interface smpg_tick_if;
    logic [1:0] sel;
    logic       tick;
    modport gen  (input sel, output tick);
    modport user (output sel, input tick);
endinterface

// ===== smpg_top.sv
// Stepper motor pulse generator with Avalon-MM register slave and four phase outputs.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "smpg_params.svh"
module smpg_top
    import smpg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        timer3_match,
    input  wire logic        low_speed_oscillator,
    input  wire logic        debug_break,
    output logic      [3:0]  phase_out,
    output logic             evt_reload,
    output logic             evt_halt,
    output logic             evt_restart
);
    function automatic logic [3:0] pat_of(smpg_mode_t m, logic [2:0] p, logic first);
        logic [3:0] one;
        one = 4'h1 << (m == SMPG_ONE_TWO ? p[2:1] : p[1:0]);
        if (m == SMPG_TWO_PHASE || (m == SMPG_ONE_TWO && p[0] && !first))
            pat_of = one | {one[2:0], one[3]};
        else
            pat_of = one;
    endfunction

    function automatic logic ext_of(logic [1:0] frac, logic [1:0] ph);
        case (frac)
            2'h1:    ext_of = (ph == 2'h1);
            2'h2:    ext_of = (ph == 2'h0) || (ph == 2'h2);
            2'h3:    ext_of = (ph != 2'h3);
            default: ext_of = 1'b0;
        endcase
    endfunction

    smpg_tick_if tif ();
    smpg_tick_gen u_tick (
        .clk                  (clk),
        .reset_n              (reset_n),
        .timer3_match         (timer3_match),
        .low_speed_oscillator (low_speed_oscillator),
        .tif                  (tif)
    );

    logic [7:0]  ctrl_q;
    logic [5:0]  wave_q;
    logic [15:0] per_q;
    logic [15:0] rise_q;
    logic [7:0]  steps_q;
    logic        stepflg_q;
    logic        haltflg_q;
    logic        ack_q;
    logic [1:0]  brk_sync_q;
    smpg_seg_t   st1_q;
    smpg_seg_t   st2_q;
    smpg_seg_t   act_q;
    smpg_state_t state_q;
    logic [10:0] cnt_q;
    logic [7:0]  nstep_q;
    logic [2:0]  pos_q;
    logic        first_q;
    logic        zero_q;
    logic [3:0]  prev_q;

    wire         tk        = tif.tick;
    wire         run       = ctrl_q[`SMPG_CTRL_RUN];
    wire smpg_mode_t mode  = smpg_mode_t'(wave_q[`SMPG_WAVE_MODE_LO +: 2]);
    wire smpg_brk_t  brk   = smpg_brk_t'(rise_q[`SMPG_RISE_BRK_LO +: 2]);
    wire         brk_on    = brk_sync_q[1];
    wire         req       = avs_read | avs_write;
    wire         wr_go     = avs_write & ack_q;
    wire         hit_ctrl  = avs_address == `SMPG_OFS_CTRL;
    wire         hit_wave  = avs_address == `SMPG_OFS_WAVE;
    wire         hit_per   = avs_address == `SMPG_OFS_PERIOD;
    wire         hit_rise  = avs_address == `SMPG_OFS_RISE;
    wire         hit_steps = avs_address == `SMPG_OFS_STEPS;
    wire         hit_stat  = avs_address == `SMPG_OFS_STATUS;
    wire [1:0]   ph        = (mode == SMPG_ONE_TWO) ? pos_q[2:1] : pos_q[1:0];
    wire [10:0]  len_raw   = {1'b0, act_q.period} + {10'h0, ext_of(act_q.ext, ph)};
    wire [10:0]  step_len  = (len_raw == 11'h0) ? 11'h1 : len_raw;
    wire         brk_now   = brk_on && (brk == SMPG_BRK_ZERO || brk == SMPG_BRK_HOLD);
    wire         step_end  = (state_q == SMPG_RUN) && tk && !brk_now && (cnt_q + 11'h1 >= step_len);
    wire         seg_end   = (act_q.steps == 8'h0) || (nstep_q == act_q.steps);
    wire [2:0]   pos_mask  = (mode == SMPG_ONE_TWO) ? 3'h7 : 3'h3;
    wire [2:0]   pos_next  = (act_q.dir ? pos_q - 3'h1 : pos_q + 3'h1) & pos_mask;
    wire [3:0]   pat       = pat_of(mode, pos_q, first_q);
    wire         rise_ok   = cnt_q >= {1'b0, act_q.lowp};
    wire         do_reload = step_end && seg_end && !st2_q.stop && !(brk_on && brk == SMPG_BRK_STEP_END);
    wire         do_halt   = step_end && seg_end && st2_q.stop;
    wire         do_resume = (state_q == SMPG_HALT) && tk && !st2_q.stop && run;
    wire smpg_seg_t live   = '{period: {per_q[`SMPG_PER_HIGH_LO +: 4], per_q[`SMPG_PER_LOW_LO +: 6]},
                               ext: per_q[1:0], dir: per_q[`SMPG_PER_DIR], stop: per_q[`SMPG_PER_STOP],
                               lowp: {rise_q[`SMPG_RISE_HIGH_LO +: 2], rise_q[7:0]}, steps: steps_q};
    wire [31:0]  rd_mux    = hit_ctrl  ? {24'h0, haltflg_q, stepflg_q, ctrl_q[5:0]} :
                             hit_wave  ? {26'h0, wave_q} :
                             hit_per   ? {16'h0, per_q} :
                             hit_rise  ? {16'h0, rise_q} :
                             hit_steps ? {24'h0, steps_q} :
                             hit_stat  ? {16'h0, nstep_q, 4'h0, phase_out} : 32'h0;

    assign tif.sel         = ctrl_q[`SMPG_CTRL_CKSEL_LO +: 2];
    assign avs_waitrequest = req & ~ack_q;
    assign evt_reload      = do_reload;
    assign evt_halt        = do_halt;
    assign evt_restart     = do_resume;

    // Every access waits exactly one cycle so read data can come from a flip-flop.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0;
            brk_sync_q   <= 2'h0;
        end
        else
        begin
            ack_q        <= req & ~ack_q;
            avs_readdata <= (avs_read & ~ack_q) ? rd_mux : avs_readdata;
            brk_sync_q   <= {brk_sync_q[0], debug_break};
        end
    end

    // Partial writes to the 16-bit pairs are taken byte by byte; software keeps them whole.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q  <= `SMPG_CTRL_RESET;
            wave_q  <= `SMPG_WAVE_RESET;
            per_q   <= `SMPG_PER_RESET;
            rise_q  <= `SMPG_RISE_RESET;
            steps_q <= `SMPG_STEPS_RESET;
        end
        else
        begin
            if (wr_go && hit_ctrl && avs_byteenable[0])
                ctrl_q <= {2'h0, avs_writedata[5:0]};
            if (wr_go && hit_wave && avs_byteenable[0])
                wave_q <= avs_writedata[5:0];
            if (wr_go && hit_per && avs_byteenable[0])
                per_q[7:0] <= avs_writedata[7:0];
            if (wr_go && hit_per && avs_byteenable[1])
                per_q[15:8] <= avs_writedata[15:8];
            if (wr_go && hit_rise && avs_byteenable[0])
                rise_q[7:0] <= avs_writedata[7:0];
            if (wr_go && hit_rise && avs_byteenable[1])
                rise_q[15:8] <= avs_writedata[15:8];
            if (wr_go && hit_steps && avs_byteenable[0])
                steps_q <= avs_writedata[7:0];
        end
    end

    // Flags clear on a written one; a same-cycle hardware event wins.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stepflg_q <= 1'b0;
            haltflg_q <= 1'b0;
        end
        else
        begin
            if (do_reload || do_resume)
                stepflg_q <= 1'b1;
            else if (wr_go && hit_ctrl && avs_byteenable[0] && avs_writedata[`SMPG_CTRL_STEPFLG])
                stepflg_q <= 1'b0;
            if (do_halt)
                haltflg_q <= 1'b1;
            else if (wr_go && hit_ctrl && avs_byteenable[0] && avs_writedata[`SMPG_CTRL_HALTFLG])
                haltflg_q <= 1'b0;
        end
    end

    // Two count clock stages keep late writes away from the coming reload.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st1_q <= '0;
            st2_q <= '0;
        end
        else if (tk)
        begin
            st1_q <= live;
            st2_q <= st1_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= SMPG_IDLE;
            act_q   <= '0;
            cnt_q   <= 11'h0;
            nstep_q <= 8'h0;
            pos_q   <= 3'h0;
            first_q <= 1'b0;
            zero_q  <= 1'b0;
            prev_q  <= 4'h0;
        end
        else if (!run)
        begin
            state_q <= SMPG_IDLE;
            zero_q  <= 1'b0;
        end
        else
        begin
            case (state_q)
                SMPG_IDLE:
                begin
                    state_q <= SMPG_RUN;
                    act_q   <= live;
                    cnt_q   <= 11'h0;
                    nstep_q <= 8'h0;
                    pos_q   <= (mode == SMPG_ONE_TWO) ? (live.dir ? 3'h7 : 3'h1) : 3'h0;
                    first_q <= 1'b1;
                    prev_q  <= 4'h0;
                end
                SMPG_RUN:
                begin
                    if (brk_now)
                    begin
                        state_q <= SMPG_BREAK;
                        zero_q  <= (brk == SMPG_BRK_ZERO);
                    end
                    else if (step_end)
                    begin
                        cnt_q   <= 11'h0;
                        pos_q   <= pos_next;
                        first_q <= 1'b0;
                        prev_q  <= pat;
                        nstep_q <= seg_end ? 8'h0 : nstep_q + 8'h1;
                        if (do_halt)
                            state_q <= SMPG_HALT;
                        else if (brk_on && brk == SMPG_BRK_STEP_END)
                            state_q <= SMPG_BREAK;
                        if (do_reload)
                            act_q <= st2_q;
                    end
                    else if (tk)
                        cnt_q <= cnt_q + 11'h1;
                end
                SMPG_HALT:
                begin
                    if (do_resume)
                    begin
                        state_q <= SMPG_RUN;
                        act_q   <= st2_q;
                        cnt_q   <= 11'h0;
                        nstep_q <= 8'h0;
                    end
                end
                SMPG_BREAK:
                begin
                    if (!brk_on)
                    begin
                        state_q <= SMPG_RUN;
                        zero_q  <= 1'b0;
                    end
                end
                default:
                    state_q <= SMPG_IDLE;
            endcase
        end
    end

    // A newly energised phase stays low until the rise delay has elapsed in the step.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_out <= 4'h0;
        else if (!run || state_q == SMPG_IDLE || zero_q)
            phase_out <= 4'h0;
        else if (state_q == SMPG_RUN)
            phase_out <= pat & (prev_q | {4{rise_ok}});
    end

    chk_stop_outputs_low: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(run) |=> ##1 (phase_out == 4'h0))
        else $error("phase outputs not low after run cleared");
    chk_one_phase_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SMPG_RUN && mode == SMPG_ONE_PHASE) |-> $onehot(pat))
        else $error("one-phase pattern has other than one phase");
    chk_two_phase_pair: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SMPG_RUN && mode == SMPG_TWO_PHASE) |-> ($countones(pat) == 2))
        else $error("two-phase pattern lacks two phases");
    chk_step_length: assert property (@(posedge clk) disable iff (!reset_n)
        step_end |-> (cnt_q == step_len - 11'h1))
        else $error("step ended at wrong count");
    chk_phase3_base: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SMPG_RUN && ph == 2'h3) |-> (step_len == ((act_q.period == 10'h0) ? 11'h1 : {1'b0, act_q.period})))
        else $error("phase 3 width was extended");
    chk_segment_steps: assert property (@(posedge clk) disable iff (!reset_n)
        (do_reload && act_q.steps != 8'h0) |-> (nstep_q == act_q.steps))
        else $error("reload before N plus one steps");
    chk_reload_source: assert property (@(posedge clk) disable iff (!reset_n)
        (do_reload && run) |=> (act_q == $past(st2_q)))
        else $error("reload did not take the staged values");
    chk_halt_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (do_halt && run) |=> (haltflg_q && state_q == SMPG_HALT) ##1 $stable(phase_out))
        else $error("halt did not flag or hold outputs");
    chk_restart_flag: assert property (@(posedge clk) disable iff (!reset_n)
        do_resume |=> (stepflg_q && state_q == SMPG_RUN))
        else $error("restart did not set step count flag");
    chk_break_zeroed: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == SMPG_BREAK && zero_q && run) |=> (phase_out == 4'h0))
        else $error("break zero mode left outputs driven");
endmodule // smpg_top

// ===== smpg_top_bench.sv
// Self-checking bench for the stepper pulse generator.
`timescale 1ns/100ps
`include "smpg_params.svh"
module smpg_top_bench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        timer3_match = 1'b0;
    logic        low_speed_oscillator = 1'b0;
    logic        debug_break = 1'b0;
    logic [3:0]  phase_out;
    logic        evt_reload;
    logic        evt_halt;
    logic        evt_restart;
    logic [15:0] steps_seen;
    logic [3:0]  src_cnt_q = 4'h0;
    int          n_fail = 0;
    int          tests_run = 0;

    always #2.5 clk = ~clk;

    // Slow count sources: timer match rises every 8 clocks, oscillator every 16.
    always @(posedge clk)
    begin
        src_cnt_q            <= src_cnt_q + 4'h1;
        timer3_match         <= src_cnt_q[2];
        low_speed_oscillator <= src_cnt_q[3];
    end

    smpg_top u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer3_match(timer3_match),
        .low_speed_oscillator(low_speed_oscillator), .debug_break(debug_break), .phase_out(phase_out),
        .evt_reload(evt_reload), .evt_halt(evt_halt), .evt_restart(evt_restart));
    smpg_motor_model u_motor (.clk(clk), .reset_n(reset_n), .phase_in(phase_out), .steps_seen(steps_seen));

    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        stop_test();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // The request stands until the rising edge at which waitrequest is seen low; read data are taken there.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= 4'h3;
        avs_write      <= wr;
        avs_read       <= !wr;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
            begin
                q = avs_readdata;
                break;
            end
            if (i == 49)
                hang();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 16'h0000, q);
    endtask

    // Waits for the phase lines to change; n is the number of clocks the old pattern stood.
    task automatic next_step(output logic [3:0] p, output int n);
        logic [3:0] s;
        s = phase_out;
        for (n = 1; n < 3000; n++)
        begin
            @(negedge clk);
            if (phase_out !== s)
            begin
                p = phase_out;
                return;
            end
        end
        hang();
    endtask

    task automatic wait_evt(input int e, input int lim, output int n);
        logic v;
        for (n = 1; n <= lim; n++)
        begin
            @(negedge clk);
            v = (e == 0) ? evt_reload : (e == 1) ? evt_halt : evt_restart;
            if (v === 1'b1)
                return;
        end
        hang();
    endtask

    function automatic logic [3:0] rot(input logic [3:0] p, input logic dir);
        return dir ? {p[0], p[3:1]} : {p[2:0], p[3]};
    endfunction

    function automatic logic [3:0] nxt(input int mode, input logic dir, input logic [3:0] p);
        if (mode == 1)
            return ($countones(p) == 1) ? (p | rot(p, dir)) : (p & rot(p, dir));
        return rot(p, dir);
    endfunction

    function automatic logic [15:0] pw(input logic dir, input logic stop, input logic [9:0] v, input logic [1:0] ext);
        return {dir, stop, 2'b00, v, ext};
    endfunction

    task automatic start(input logic [1:0] ck, input logic [1:0] mode, input logic [15:0] per,
                         input logic [15:0] rise, input logic [15:0] steps);
        wr(`SMPG_OFS_CTRL, 16'h0000);
        wr(`SMPG_OFS_WAVE, {10'h000, mode, 4'h3});
        wr(`SMPG_OFS_PERIOD, per);
        wr(`SMPG_OFS_RISE, rise);
        wr(`SMPG_OFS_STEPS, steps);
        wr(`SMPG_OFS_CTRL, {12'h000, ck, 2'b01});
    endtask

    task automatic s_regs();
        logic [31:0] q;
        wr(5'h14, 16'hFFFF);
        wr(5'h18, 16'hFFFF);
        for (int a = 0; a < 8; a++)
        begin
            rd(5'(a * 4), q);
            check(q, 32'h0);
        end
    endtask

    task automatic s_modes();
        logic [31:0] q;
        logic [3:0]  p;
        logic [3:0]  c;
        int          n;
        for (int m = 0; m < 3; m++)
            for (int d = 0; d < 2; d++)
            begin
                start(2'b00, 2'(m), pw(1'(d), 1'b0, 10'h004, 2'b00), 16'h0000, 16'h0000);
                rd(`SMPG_OFS_WAVE, q);
                check(q, 32'(m * 16 + 3));
                @(negedge clk);
                check(32'($countones(phase_out)), 32'((m == 2) ? 2 : 1));
                next_step(p, n);
                next_step(p, n);
                for (int k = 0; k < 4; k++)
                begin
                    next_step(c, n);
                    check(32'(c), 32'(nxt(m, 1'(d), p)));
                    check(32'(n), 32'h4);
                    p = c;
                end
            end
        wr(`SMPG_OFS_CTRL, 16'h0000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(32'(phase_out), 32'h0);
    endtask

    task automatic s_ext();
        logic [3:0] p;
        logic [3:0] c;
        int         n;
        for (int e = 0; e < 4; e++)
        begin
            start(2'b00, 2'b00, pw(1'b0, 1'b0, 10'h004, 2'(e)), 16'h0000, 16'h0000);
            next_step(p, n);
            next_step(p, n);
            for (int k = 0; k < 8; k++)
            begin
                next_step(c, n);
                check(32'(n), 32'(4 + ((p[1] & e[0]) | ((p[0] | p[2]) & e[1]))));
                p = c;
            end
        end
    endtask

    task automatic s_clocks();
        logic [3:0] p;
        int         n;
        for (int i = 0; i < 2; i++)
        begin
            start(i ? 2'b11 : 2'b01, 2'b00, pw(1'b0, 1'b0, 10'h002, 2'b00), 16'h0000, 16'h0000);
            repeat (3) next_step(p, n);
            check(32'(n), i ? 32'h20 : 32'h10);
        end
    endtask

    task automatic s_segment();
        logic [31:0] q;
        logic [15:0] s0;
        int          n;
        start(2'b00, 2'b00, pw(1'b0, 1'b0, 10'h004, 2'b00), 16'h0000, 16'h0002);
        wait_evt(0, 300, n);
        s0 = steps_seen;
        wr(`SMPG_OFS_PERIOD, pw(1'b0, 1'b0, 10'h006, 2'b00));
        wr(`SMPG_OFS_STEPS, 16'h0001);
        wait_evt(0, 300, n);
        check(32'(steps_seen - s0), 32'h3);
        s0 = steps_seen;
        wait_evt(0, 300, n);
        check(32'(n), 32'hC);
        check(32'(steps_seen - s0), 32'h2);
        wr(`SMPG_OFS_CTRL, 16'h0041);
        rd(`SMPG_OFS_CTRL, q);
        check(32'(q[6]), 32'h0);
        wait_evt(0, 300, n);
        rd(`SMPG_OFS_CTRL, q);
        check(32'(q[6]), 32'h1);
    endtask

    task automatic s_halt();
        logic [31:0] q;
        logic [15:0] s0;
        logic [3:0]  p;
        int          n;
        wr(`SMPG_OFS_STEPS, 16'h0000);
        wr(`SMPG_OFS_PERIOD, pw(1'b0, 1'b1, 10'h004, 2'b00));
        wait_evt(1, 300, n);
        repeat (3) @(negedge clk);
        p = phase_out;
        s0 = steps_seen;
        repeat (30) @(negedge clk);
        check(32'(phase_out), 32'(p));
        check(32'(steps_seen), 32'(s0));
        rd(`SMPG_OFS_CTRL, q);
        check(32'(q[7]), 32'h1);
        wr(`SMPG_OFS_PERIOD, pw(1'b0, 1'b0, 10'h004, 2'b00));
        wait_evt(2, 4, n);
        next_step(p, n);
        wr(`SMPG_OFS_CTRL, 16'h0081);
        rd(`SMPG_OFS_CTRL, q);
        check(q[7:6], 2'b01);
    endtask

    task automatic s_rise();
        logic [3:0] c;
        int         n;
        start(2'b00, 2'b00, pw(1'b0, 1'b0, 10'h006, 2'b00), 16'h0002, 16'h0000);
        c = 4'hF;
        for (int k = 0; k < 6 && c !== 4'h0; k++)
            next_step(c, n);
        next_step(c, n);
        check(32'(n), 32'h2);
    endtask

    task automatic s_break();
        logic [3:0] p;
        logic [3:0] e;
        for (int b = 0; b < 4; b++)
        begin
            start(2'b00, 2'b00, pw(1'b0, 1'b0, 10'h004, 2'b00), {1'b0, 2'(b), 13'h0000}, 16'h0000);
            repeat (10) @(posedge clk);
            debug_break <= 1'b1;
            repeat (20) @(negedge clk);
            p = phase_out;
            e = (b == 0) ? rot(p, 1'b0) : (b == 2) ? 4'h0 : p;
            repeat (20) @(negedge clk);
            check(32'(phase_out), 32'(e));
            @(posedge clk);
            debug_break <= 1'b0;
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        s_regs();
        s_modes();
        s_ext();
        s_clocks();
        s_segment();
        s_halt();
        s_rise();
        s_break();
        stop_test();
    end
endmodule // smpg_top_bench
